// file: shared/rut_pkg.sv
// Purpose: Shared constants for the reload up/down timer.
// Assumes: 50 MHz core clock; count tick is the core clock divided by twelve.
// Notes:   Mode codes come from the receive, transmit and capture/reload select bits.
`default_nettype none
package rut_pkg;
   localparam int unsigned   TICK_DIVIDE  = 12;
   localparam logic [3:0]    DIV_LAST     = 4'hb;
   localparam logic [3:0]    DIV_RESET    = 4'h0;
   localparam logic [7:0]    BYTE_RESET   = 8'h00;
   localparam logic [7:0]    BYTE_FULL    = 8'hff;
   localparam logic [15:0]   COUNT_FULL   = 16'hffff;
   typedef enum logic [1:0] {
      RUT_MODE_CAPTURE = 2'b00,
      RUT_MODE_RELOAD  = 2'b01,
      RUT_MODE_BAUD    = 2'b10
   } rut_mode_t;
endpackage : rut_pkg
`default_nettype wire

// file: design/rut_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to CLOCK.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module rut_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Data
   input  wire logic d,
   output var  logic q
);
   logic meta_q;
   logic meta_d;
   logic q_d;

   // Next values
   always_comb begin
      meta_d = d;
      q_d    = meta_q;
   end

   // Two stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= meta_d;
         q      <= q_d;
      end
   end
endmodule : rut_sync
`default_nettype wire

// file: design/rut_timer.sv
// Purpose: 16-bit timer/counter with auto-reload and up/down counting.
// Assumes: Software bits arrive as plain synchronous ports; pins are asynchronous.
// Notes:   Capture mode captures the count on a direction pin falling edge.
//
// Contract
// - The count is a low byte and a high byte, the high byte stepping on low byte carry.
// - The count source is the core clock divided by twelve, or events on the count pin.
// - The low byte advances only while the run bit is set, otherwise the count holds; the code still loads it on a count write or an event reload.
// - Capture, auto-reload and baud modes are picked by the receive, transmit and reload bits.
// - Auto-reload with down-count clear is the classic timer, set gives up/down by direction pin.
// - Counting up in up/down mode, a wrap past FFFFh sets the overflow flag and an interrupt.
// - An upward overflow in up/down mode loads the reload pair into the count.
// - Counting down, a count equal to the reload pair is the underflow condition.
// - A downward underflow sets the overflow flag and loads FFFFh into the count.
// - In up/down mode the external flag toggles on every overflow or underflow.
// - In up/down mode the external flag never raises an interrupt request.
// - Auto-reload mode is a self-reloading 16-bit timer or event counter.
// - With events enabled, a direction pin fall that captures or reloads sets the external flag.
// - With the receive clock bit set, timer overflows become the serial receive clock.
`timescale 1ns/1ps
`default_nettype none
module rut_timer (
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   // Pins
   input  wire logic        EXTERNAL_COUNT_PIN,
   input  wire logic        DIRECTION_PIN,
   // Control bits
   input  wire logic        COUNT_SOURCE_SELECT,
   input  wire logic        RUN_CONTROL_BIT,
   input  wire logic        RECEIVE_CLOCK_SELECT,
   input  wire logic        TRANSMIT_CLOCK_SELECT,
   input  wire logic        CAPTURE_RELOAD_SELECT,
   input  wire logic        DOWN_COUNT_ENABLE,
   input  wire logic        EXTERNAL_EVENT_ENABLE,
   input  wire logic        TIMER_INT_ENABLE,
   // Software writes
   input  wire logic        COUNT_WRITE,
   input  wire logic [15:0] COUNT_WRITE_VALUE,
   input  wire logic        RELOAD_WRITE,
   input  wire logic [15:0] RELOAD_WRITE_VALUE,
   input  wire logic        OVERFLOW_FLAG_CLEAR,
   input  wire logic        EXTERNAL_FLAG_CLEAR,
   // Status
   output var  logic [7:0]  COUNT_LOW_BYTE,
   output var  logic [7:0]  COUNT_HIGH_BYTE,
   output var  logic [7:0]  RELOAD_LOW_BYTE,
   output var  logic [7:0]  RELOAD_HIGH_BYTE,
   output var  logic        OVERFLOW_FLAG,
   output var  logic        EXTERNAL_FLAG,
   output var  logic        INTERRUPT_REQUEST,
   output var  logic        RECEIVE_CLOCK_PULSE,
   output var  logic        TRANSMIT_CLOCK_PULSE
);
   // Reset release
   logic rst_a_q;
   logic rst_q;
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_a_q <= 1'b0;
         rst_q   <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_q   <= rst_a_q;
      end
   end

   // Pin synchronisers
   logic cnt_pin_s;
   logic dir_pin_s;
   rut_sync u_sync_cnt (
      .clk   (CLOCK),
      .rst_n (rst_q),
      .d     (EXTERNAL_COUNT_PIN),
      .q     (cnt_pin_s)
   );
   rut_sync u_sync_dir (
      .clk   (CLOCK),
      .rst_n (rst_q),
      .d     (DIRECTION_PIN),
      .q     (dir_pin_s)
   );

   // Mode decode; either serial clock bit wins over capture/reload
   rut_pkg::rut_mode_t mode;
   always_comb begin
      if (RECEIVE_CLOCK_SELECT || TRANSMIT_CLOCK_SELECT) begin
         mode = rut_pkg::RUT_MODE_BAUD;
      end else if (CAPTURE_RELOAD_SELECT) begin
         mode = rut_pkg::RUT_MODE_CAPTURE;
      end else begin
         mode = rut_pkg::RUT_MODE_RELOAD;
      end
   end

   // State
   logic [3:0]  div_q, div_d;
   logic        cnt_prev_q, cnt_prev_d;
   logic        dir_prev_q, dir_prev_d;
   logic [7:0]  low_q, low_d;
   logic [7:0]  high_q, high_d;
   logic [15:0] rld_q, rld_d;
   logic        ovf_q, ovf_d;
   logic        exf_q, exf_d;
   logic        irq_q, irq_d;
   logic        rxp_q, rxp_d;
   logic        txp_q, txp_d;

   // Working terms
   logic        tick;
   logic        step;
   logic        updown;
   logic        count_up;
   logic        low_carry;
   logic        wrap_up;
   logic        wrap_down;
   logic        dir_fall;
   logic        ext_event;
   logic [15:0] count;
   logic        set_ovf;
   logic        set_exf;
   logic        tog_exf;
   logic        exf_irq;

   // Next-state computation
   always_comb begin
      div_d      = div_q;
      cnt_prev_d = cnt_pin_s;
      dir_prev_d = dir_pin_s;
      low_d      = low_q;
      high_d     = high_q;
      rld_d      = rld_q;
      rxp_d      = 1'b0;
      txp_d      = 1'b0;
      set_ovf    = 1'b0;
      set_exf    = 1'b0;
      tog_exf    = 1'b0;
      count      = {high_q, low_q};
      // Divide by twelve enable; falling edge on the count pin is an event
      tick       = (div_q == rut_pkg::DIV_LAST);
      if (tick) begin
         div_d = rut_pkg::DIV_RESET;
      end else begin
         div_d = div_q + 4'h1;
      end
      step       = RUN_CONTROL_BIT &&
                   (COUNT_SOURCE_SELECT ? (cnt_prev_q && !cnt_pin_s) : tick);
      updown     = (mode == rut_pkg::RUT_MODE_RELOAD) && DOWN_COUNT_ENABLE;
      count_up   = !updown || dir_pin_s;
      low_carry  = (low_q == rut_pkg::BYTE_FULL);
      wrap_up    = count_up && (count == rut_pkg::COUNT_FULL);
      wrap_down  = !count_up && (count == rld_q);
      dir_fall   = dir_prev_q && !dir_pin_s;
      // Up/down counting owns the direction pin, so its edges are not events there
      ext_event  = EXTERNAL_EVENT_ENABLE && dir_fall && !updown;
      if (step) begin
         if (wrap_up) begin
            if (mode == rut_pkg::RUT_MODE_CAPTURE) begin
               {high_d, low_d} = {rut_pkg::BYTE_RESET, rut_pkg::BYTE_RESET};
            end else begin
               {high_d, low_d} = rld_q;
            end
            if (mode == rut_pkg::RUT_MODE_BAUD) begin
               rxp_d = RECEIVE_CLOCK_SELECT;
               txp_d = TRANSMIT_CLOCK_SELECT;
            end else begin
               set_ovf = 1'b1;
            end
            tog_exf = updown;
         end else if (wrap_down) begin
            {high_d, low_d} = rut_pkg::COUNT_FULL;
            set_ovf = 1'b1;
            tog_exf = 1'b1;
         end else if (count_up) begin
            low_d = low_q + 8'h01;
            if (low_carry) begin
               high_d = high_q + 8'h01;
            end
         end else begin
            low_d = low_q - 8'h01;
            if (low_q == rut_pkg::BYTE_RESET) begin
               high_d = high_q - 8'h01;
            end
         end
      end
      // Direction pin falling edge captures or forces a reload
      if (ext_event) begin
         if (mode == rut_pkg::RUT_MODE_CAPTURE) begin
            rld_d = count;
         end else if (mode == rut_pkg::RUT_MODE_RELOAD) begin
            {high_d, low_d} = rld_q;
         end
         // Baud mode neither captures nor reloads, so the edge raises no flag there
         set_exf = (mode != rut_pkg::RUT_MODE_BAUD);
      end
      // Software writes yield to hardware loads only for the reload pair capture
      if (COUNT_WRITE) begin
         {high_d, low_d} = COUNT_WRITE_VALUE;
      end
      if (RELOAD_WRITE && !(ext_event && mode == rut_pkg::RUT_MODE_CAPTURE)) begin
         rld_d = RELOAD_WRITE_VALUE;
      end
      // Flags: a hardware set wins over a software clear in the same cycle
      ovf_d = set_ovf || (ovf_q && !OVERFLOW_FLAG_CLEAR);
      if (set_exf) begin
         exf_d = 1'b1;
      end else if (tog_exf) begin
         exf_d = !exf_q;
      end else begin
         exf_d = exf_q && !EXTERNAL_FLAG_CLEAR;
      end
      // External flag requests nothing while counting up/down
      exf_irq = exf_d && !updown;
      irq_d   = TIMER_INT_ENABLE && (ovf_d || exf_irq);
   end

   // Registers
   always_ff @(posedge CLOCK or negedge rst_q) begin
      if (!rst_q) begin
         div_q      <= rut_pkg::DIV_RESET;
         cnt_prev_q <= 1'b0;
         dir_prev_q <= 1'b0;
         low_q      <= rut_pkg::BYTE_RESET;
         high_q     <= rut_pkg::BYTE_RESET;
         rld_q      <= {rut_pkg::BYTE_RESET, rut_pkg::BYTE_RESET};
         ovf_q      <= 1'b0;
         exf_q      <= 1'b0;
         irq_q      <= 1'b0;
         rxp_q      <= 1'b0;
         txp_q      <= 1'b0;
      end else begin
         div_q      <= div_d;
         cnt_prev_q <= cnt_prev_d;
         dir_prev_q <= dir_prev_d;
         low_q      <= low_d;
         high_q     <= high_d;
         rld_q      <= rld_d;
         ovf_q      <= ovf_d;
         exf_q      <= exf_d;
         irq_q      <= irq_d;
         rxp_q      <= rxp_d;
         txp_q      <= txp_d;
      end
   end

   // Outputs straight from flops
   always_comb begin
      COUNT_LOW_BYTE       = low_q;
      COUNT_HIGH_BYTE      = high_q;
      RELOAD_LOW_BYTE      = rld_q[7:0];
      RELOAD_HIGH_BYTE     = rld_q[15:8];
      OVERFLOW_FLAG        = ovf_q;
      EXTERNAL_FLAG        = exf_q;
      INTERRUPT_REQUEST    = irq_q;
      RECEIVE_CLOCK_PULSE  = rxp_q;
      TRANSMIT_CLOCK_PULSE = txp_q;
   end

   // Checks
   chk_run_hold: assert property (@(posedge CLOCK) disable iff (!rst_q)
      (!RUN_CONTROL_BIT && !COUNT_WRITE && !ext_event) |=> $stable({high_q, low_q}))
      else $error("count moved while stopped");
   chk_up_reload: assert property (@(posedge CLOCK) disable iff (!rst_q)
      (step && wrap_up && mode == rut_pkg::RUT_MODE_RELOAD && !COUNT_WRITE && !ext_event)
      |=> ({high_q, low_q} == $past(rld_q)) && ovf_q)
      else $error("overflow did not reload");
   chk_down_wrap: assert property (@(posedge CLOCK) disable iff (!rst_q)
      (step && wrap_down && !COUNT_WRITE && !ext_event)
      |=> ({high_q, low_q} == rut_pkg::COUNT_FULL) && ovf_q)
      else $error("underflow did not load full count");
   chk_ext_toggle: assert property (@(posedge CLOCK) disable iff (!rst_q)
      (step && updown && (wrap_up || wrap_down) && !ext_event) |=> (exf_q != $past(exf_q)))
      else $error("external flag did not toggle");
   chk_ext_noirq: assert property (@(posedge CLOCK) disable iff (!rst_q)
      (updown && !ovf_d) |=> !irq_q)
      else $error("request raised by external flag");
   chk_ovf_sticky: assert property (@(posedge CLOCK) disable iff (!rst_q)
      (ovf_q && !OVERFLOW_FLAG_CLEAR) |=> ovf_q)
      else $error("overflow flag dropped");
   chk_irq_follow: assert property (@(posedge CLOCK) disable iff (!rst_q)
      (ovf_q && TIMER_INT_ENABLE && !OVERFLOW_FLAG_CLEAR) |=> irq_q)
      else $error("request not following flag");
   chk_step_tick: assert property (@(posedge CLOCK) disable iff (!rst_q)
      (tick && !COUNT_SOURCE_SELECT) |=> (!tick) [*8])
      else $error("divider ticks too often");
endmodule : rut_timer
`default_nettype wire

// file: tb/rut_pin_model.sv
// Purpose: Pin model for the count pin and the direction pin.
// Assumes: Requests from the bench change at the falling edge.
// Notes:   The count pin idles high; a pulse is low for a chosen number of cycles.
`timescale 1ns/1ps
`default_nettype none
module rut_pin_model (
   // Clock
   input  wire logic       clk,
   // Requests from the bench
   input  wire logic       pulse_req,
   input  wire logic [3:0] pulse_len,
   input  wire logic       dir_req,
   // Pins
   output var  logic       count_pin,
   output var  logic       dir_pin
);
   logic [3:0] low_q = 4'h0;
   logic [3:0] low_d;
   // A new pulse starts only once the last one is over, so pulses never merge
   always_comb begin
      low_d = low_q;
      if (pulse_req && low_q == 4'h0) begin
         low_d = pulse_len;
      end else if (low_q != 4'h0) begin
         low_d = low_q - 4'h1;
      end
   end
   // Pins move just after the edge, as a board driver would
   always_ff @(posedge clk) begin
      low_q   <= low_d;
      dir_pin <= dir_req;
   end
   assign count_pin = (low_q == 4'h0);
endmodule : rut_pin_model
`default_nettype wire

// file: tb/tb_reload_updown_timer.sv
// Purpose: Self-checking bench for the reload up/down timer.
// Assumes: Software bits change at the falling edge; pins come from the pin model.
// Notes:   Every wait is bounded; a stuck wait counts as a mismatch.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_reload_updown_timer;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        src, run, rclk, transmit_clock_select, cpr, down_count_enable, exen, ien, cw, rw, ofc, efc, preq, dreq;
   logic [15:0] cwv, rwv;
   logic [3:0]  plen;
   wire  logic  cpin, dpin;
   logic [7:0]  clo, chi, rlo, rhi;
   logic        ovf, exf, irq, rxp, txp;
   wire  logic [15:0] cnt = {chi, clo};
   wire  logic [15:0] rld = {rhi, rlo};
   int          err_total = 0;
   int          checked = 0;
   // Core clock, 20 ns period
   always #10 clk = ~clk;
   rut_pin_model pins (.clk(clk), .pulse_req(preq), .pulse_len(plen), .dir_req(dreq),
      .count_pin(cpin), .dir_pin(dpin));
   rut_timer dut (.CLOCK(clk), .RESET_N(rst_n), .EXTERNAL_COUNT_PIN(cpin), .DIRECTION_PIN(dpin),
      .COUNT_SOURCE_SELECT(src), .RUN_CONTROL_BIT(run), .RECEIVE_CLOCK_SELECT(rclk),
      .TRANSMIT_CLOCK_SELECT(transmit_clock_select), .CAPTURE_RELOAD_SELECT(cpr), .DOWN_COUNT_ENABLE(down_count_enable),
      .EXTERNAL_EVENT_ENABLE(exen), .TIMER_INT_ENABLE(ien), .COUNT_WRITE(cw),
      .COUNT_WRITE_VALUE(cwv), .RELOAD_WRITE(rw), .RELOAD_WRITE_VALUE(rwv),
      .OVERFLOW_FLAG_CLEAR(ofc), .EXTERNAL_FLAG_CLEAR(efc), .COUNT_LOW_BYTE(clo),
      .COUNT_HIGH_BYTE(chi), .RELOAD_LOW_BYTE(rlo), .RELOAD_HIGH_BYTE(rhi),
      .OVERFLOW_FLAG(ovf), .EXTERNAL_FLAG(exf), .INTERRUPT_REQUEST(irq),
      .RECEIVE_CLOCK_PULSE(rxp), .TRANSMIT_CLOCK_PULSE(txp));
   task automatic finish_test;
      if (err_total == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   // A wait that ran out ends the run at once rather than cascading
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         err_total++;
         finish_test();
      end
   endtask : guard
   task automatic load(input logic [15:0] c, input logic [15:0] r);
      cw = 1'b1; rw = 1'b1; cwv = c; rwv = r;
      step(1);
      cw = 1'b0; rw = 1'b0;
   endtask : load
   task automatic clr;
      ofc = 1'b1; efc = 1'b1;
      step(1);
      ofc = 1'b0; efc = 1'b0;
   endtask : clr
   // Counts falling edges until the count leaves its old value
   task automatic wait_cnt(input logic [15:0] old, output int n);
      for (n = 0; n < 300 && cnt === old; n++) step(1);
      guard(n, 300);
   endtask : wait_cnt
   task automatic t_classic;
      int n;
      load(16'hfffe, 16'h1234);
      run = 1'b1;
      wait_cnt(16'hfffe, n);
      `CHK(cnt, 16'hffff)
      wait_cnt(16'hffff, n);
      `CHK(n, 12)
      `CHK(cnt, 16'h1234)
      `CHK({ovf, irq}, 2'b11)
      step(30);
      `CHK(ovf, 1'b1)
      ien = 1'b0;
      step(2);
      `CHK(irq, 1'b0)
      ien = 1'b1; run = 1'b0;
      clr();
      // Run stayed up 32 cycles after the reload, so two ticks stepped the count
      `CHK(cnt, 16'h1236)
      step(40);
      `CHK({cnt, ovf, irq}, {16'h1236, 2'b00})
   endtask : t_classic
   task automatic t_updown;
      int n;
      down_count_enable = 1'b1;
      load(16'hffff, 16'h8000);
      run = 1'b1;
      wait_cnt(16'hffff, n);
      `CHK(cnt, 16'h8000)
      `CHK({ovf, exf, irq}, 3'b111)
      ofc = 1'b1;
      step(1);
      ofc = 1'b0;
      step(1);
      `CHK({exf, irq}, 2'b10)
      run = 1'b0; dreq = 1'b0;
      load(16'h8001, 16'h8000);
      step(4);
      run = 1'b1;
      wait_cnt(16'h8001, n);
      `CHK(cnt, 16'h8000)
      wait_cnt(16'h8000, n);
      `CHK({cnt, ovf, exf}, {16'hffff, 2'b10})
      run = 1'b0; down_count_enable = 1'b0; dreq = 1'b1;
      clr();
   endtask : t_updown
   // Short and long pulses on the count pin; the second one carries into the high byte
   task automatic t_counter;
      src = 1'b1;
      load(16'h00fe, 16'h0000);
      run = 1'b1;
      for (int i = 0; i < 3; i++) begin
         plen = 4'(2 + 3 * i);
         preq = 1'b1;
         step(1);
         preq = 1'b0;
         step(24);
      end
      `CHK(cnt, 16'h0101)
      run = 1'b0; src = 1'b0;
   endtask : t_counter
   // Direction pin falls with events on: reload first, then capture
   task automatic t_event;
      int n;
      exen = 1'b1;
      for (int i = 0; i < 2; i++) begin
         cpr = i[0];
         load(16'h5a5a, 16'h4321);
         clr();
         step(4);
         dreq = 1'b0;
         for (n = 0; n < 20 && exf !== 1'b1; n++) step(1);
         guard(n, 20);
         `CHK({exf, irq}, 2'b11)
         `CHK({cnt, rld}, i ? 32'h5a5a5a5a : 32'h43214321)
         efc = 1'b1;
         step(1);
         efc = 1'b0; dreq = 1'b1;
         step(1);
         `CHK({exf, irq}, 2'b00)
      end
      exen = 1'b0; cpr = 1'b0;
   endtask : t_event
   task automatic t_baud;
      int n;
      for (int i = 0; i < 2; i++) begin
         rclk = ~i[0]; transmit_clock_select = i[0];
         load(16'hfffe, 16'hfff0);
         run = 1'b1;
         for (n = 0; n < 100 && (i ? txp : rxp) !== 1'b1; n++) step(1);
         guard(n, 100);
         `CHK({ovf, i ? txp : rxp}, 2'b01)
         run = 1'b0;
      end
      rclk = 1'b0; transmit_clock_select = 1'b0;
   endtask : t_baud
   // Main sequence
   initial begin
      {src, run, rclk, transmit_clock_select, cpr, down_count_enable, exen, cw, rw, ofc, efc, preq} = 12'h000;
      ien = 1'b1; dreq = 1'b1; plen = 4'h2; cwv = 16'h0000; rwv = 16'h0000;
      step(15);
      `CHK({cnt, rld, ovf, exf, irq, rxp, txp}, 37'h0)
      step(1);
      rst_n = 1'b1;
      step(6);
      t_classic();
      t_updown();
      t_counter();
      t_event();
      t_baud();
      finish_test();
   end
endmodule : tb_reload_updown_timer
`default_nettype wire
